// File: design/coef_if.sv
`timescale 1ns/100ps
`default_nettype none
interface coef_if;
   logic signed [fir_coef_pkg::COEF_W-1:0] outer [fir_coef_pkg::NUM_OUTER];
   logic signed [fir_coef_pkg::CENTER_W-1:0] center;
   modport src (output outer, output center);
   modport sink (input outer, input center);
endinterface
`default_nettype wire

// File: design/coef_store.sv
`timescale 1ns/100ps
`default_nettype none
module coef_store #(
   parameter int W = 16,
   parameter int MSB = 11,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic we_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] value_o,
   output logic [W-1:0] readback_o
);
   logic [W-1:0] value_q;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         value_q <= RST;
      end else if (we_i) begin
         value_q <= wdata_i;
      end
   end

   assign value_o = value_q;
   // Field top bit never returns on read
   assign readback_o = value_q & ~(W'(1) << MSB); // RULE6
endmodule
`default_nettype wire

// File: design/fir9_filter.sv
`timescale 1ns/100ps
`default_nettype none
module fir9_filter (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic valid_i,
   input wire logic signed [fir_coef_pkg::SAMPLE_W-1:0] sample_i,
   coef_if.sink coefs,
   output logic signed [fir_coef_pkg::ACC_W-1:0] y_o,
   output logic y_valid_o
);
   logic signed [fir_coef_pkg::SAMPLE_W-1:0] taps_q [fir_coef_pkg::NUM_TAPS];
   logic signed [fir_coef_pkg::ACC_W-1:0] acc;
   logic valid_q;

   // Newest sample sits at index 0
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < fir_coef_pkg::NUM_TAPS; i++) begin
            taps_q[i] <= '0;
         end
      end else if (valid_i) begin
         taps_q[0] <= sample_i; // RULE10
         for (int i = 1; i < fir_coef_pkg::NUM_TAPS; i++) begin
            taps_q[i] <= taps_q[i-1];
         end
      end
   end

   always_comb begin
      acc = fir_coef_pkg::ACC_W'(taps_q[fir_coef_pkg::CENTER_IDX]
         * coefs.center); // RULE8
      for (int k = 0; k < fir_coef_pkg::NUM_OUTER; k++) begin
         if (k < fir_coef_pkg::CENTER_IDX) begin
            acc = acc + fir_coef_pkg::ACC_W'(taps_q[k] * coefs.outer[k]);
         end else begin
            acc = acc + fir_coef_pkg::ACC_W'(taps_q[k+1] * coefs.outer[k]);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         valid_q <= 1'b0;
         y_valid_o <= 1'b0;
         y_o <= '0;
      end else begin
         valid_q <= valid_i;
         y_valid_o <= valid_q;
         if (valid_q) begin
            y_o <= acc; // RULE10
         end
      end
   end
endmodule
`default_nettype wire

// File: design/fir_coef_pkg.sv
package fir_coef_pkg;
   // Widths
   localparam int ADDR_W = 12;
   localparam int REG_W = 16;
   localparam int COEF_W = 12;
   localparam int CENTER_W = 18;
   localparam int SAMPLE_W = 12;
   localparam int ACC_W = 34;
   localparam int CNT_W = 16;
   // Filter shape
   localparam int NUM_TAPS = 9;
   localparam int NUM_OUTER = 8;
   localparam int CENTER_IDX = 4;
   localparam int NUM_COEF_REGS = 5;
   localparam int NUM_A_LOW = 4;
   localparam int NUM_B_EXT = 7;
   // Field positions
   localparam int COEF_MSB = 11;
   localparam int CTRL_SINGLE_BIT = 0;
   // Register offsets
   localparam logic [ADDR_W-1:0] CHAN_A_TAP6_OFF = 12'h423;
   localparam logic [ADDR_W-1:0] CHAN_A_TAP7_OFF = 12'h425;
   localparam logic [ADDR_W-1:0] CHAN_A_TAP8_OFF = 12'h427;
   localparam logic [ADDR_W-1:0] CHAN_A_TAP9_OFF = 12'h429;
   localparam logic [ADDR_W-1:0] CHAN_B_TAP1_OFF = 12'h448;
   localparam logic [ADDR_W-1:0] FILTER_CTRL_OFF = 12'h460;
   localparam logic [ADDR_W-1:0] FILTER_STATUS_OFF = 12'h462;
   // Reset values
   localparam logic [REG_W-1:0] COEF_RST = 16'h0000;
   localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
endpackage

// File: design/fir_tap_coefficient_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RULE1] Each 12-bit coefficient field is a signed two's-complement value.
// [RULE2] Register 0x423 is tap six of channel A and single filters.
// [RULE3] Register 0x425 is tap seven of channel A and single filters.
// [RULE4] Register 0x427 is tap eight of channel A and single filters.
// [RULE5] Register 0x429 is tap nine of channel A and single filters.
// [RULE6] Read-back shows field MSB as zero; written value still applies.
// [RULE7] Channel B tap one register at 0x448, 12-bit field, resets zero.
// [RULE8] Fifth tap is the centre tap, an 18-bit signed coefficient.
// [RULE9] Channel B set used only in dual mode; single uses channel A.
// [RULE10] Output sums nine newest samples times taps, tap one newest.
module fir_tap_coefficient_bank (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [fir_coef_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fir_coef_pkg::REG_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [fir_coef_pkg::REG_W-1:0] rdata_o,
   input wire logic sample_valid_i,
   input wire logic signed [fir_coef_pkg::SAMPLE_W-1:0] sample_a_i,
   input wire logic signed [fir_coef_pkg::SAMPLE_W-1:0] sample_b_i,
   input wire logic [fir_coef_pkg::NUM_A_LOW*fir_coef_pkg::COEF_W-1:0]
      chan_a_low_coef_i,
   input wire logic signed [fir_coef_pkg::CENTER_W-1:0]
      chan_a_center_tap_coef_i,
   input wire logic [fir_coef_pkg::NUM_B_EXT*fir_coef_pkg::COEF_W-1:0]
      chan_b_ext_coef_i,
   input wire logic signed [fir_coef_pkg::CENTER_W-1:0]
      chan_b_center_tap_coef_i,
   output logic signed [fir_coef_pkg::ACC_W-1:0] fir_a_o,
   output logic signed [fir_coef_pkg::ACC_W-1:0] fir_b_o,
   output logic fir_valid_o
);
   localparam logic [fir_coef_pkg::ADDR_W-1:0]
      COEF_OFF [fir_coef_pkg::NUM_COEF_REGS] = '{
         fir_coef_pkg::CHAN_A_TAP6_OFF,
         fir_coef_pkg::CHAN_A_TAP7_OFF,
         fir_coef_pkg::CHAN_A_TAP8_OFF,
         fir_coef_pkg::CHAN_A_TAP9_OFF,
         fir_coef_pkg::CHAN_B_TAP1_OFF
      };
   localparam int B_TAP1_IDX = 4;

   logic [fir_coef_pkg::REG_W-1:0] coef_val [fir_coef_pkg::NUM_COEF_REGS];
   logic [fir_coef_pkg::REG_W-1:0] coef_rb [fir_coef_pkg::NUM_COEF_REGS];
   logic [fir_coef_pkg::REG_W-1:0] ctrl_q;
   logic [fir_coef_pkg::CNT_W-1:0] sample_cnt_q;
   logic [fir_coef_pkg::REG_W-1:0] rdata_d;
   logic single_mode;

   coef_if coef_a ();
   coef_if coef_b ();

   // Coefficient register decode
   function automatic logic coef_hit(
      input logic [fir_coef_pkg::ADDR_W-1:0] addr,
      input int idx
   );
      coef_hit = (addr == COEF_OFF[idx]);
   endfunction

   function automatic logic any_coef_hit(
      input logic [fir_coef_pkg::ADDR_W-1:0] addr
   );
      any_coef_hit = 1'b0;
      for (int i = 0; i < fir_coef_pkg::NUM_COEF_REGS; i++) begin
         if (coef_hit(addr, i)) begin
            any_coef_hit = 1'b1;
         end
      end
   endfunction

   // Coefficient storage
   for (genvar g = 0; g < fir_coef_pkg::NUM_COEF_REGS; g++) begin : g_coef
      coef_store #(
         .W(fir_coef_pkg::REG_W),
         .MSB(fir_coef_pkg::COEF_MSB),
         .RST(fir_coef_pkg::COEF_RST)
      ) u_store (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .we_i(wr_i && coef_hit(addr_i, g)),
         .wdata_i(wdata_i),
         .value_o(coef_val[g]),
         .readback_o(coef_rb[g])
      );
   end

   // Filter mode control
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ctrl_q <= fir_coef_pkg::CTRL_RST;
      end else if (wr_i && addr_i == fir_coef_pkg::FILTER_CTRL_OFF) begin
         ctrl_q <= {{(fir_coef_pkg::REG_W-1){1'b0}},
            wdata_i[fir_coef_pkg::CTRL_SINGLE_BIT]};
      end
   end

   assign single_mode = ctrl_q[fir_coef_pkg::CTRL_SINGLE_BIT];

   // Accepted sample count
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sample_cnt_q <= fir_coef_pkg::CNT_RST;
      end else if (sample_valid_i) begin
         sample_cnt_q <= sample_cnt_q + fir_coef_pkg::CNT_W'(1);
      end
   end

   // Channel A set, also the single-mode set
   always_comb begin
      for (int k = 0; k < fir_coef_pkg::NUM_A_LOW; k++) begin
         coef_a.outer[k] = chan_a_low_coef_i[k*fir_coef_pkg::COEF_W +:
            fir_coef_pkg::COEF_W];
      end
      coef_a.outer[4] = $signed(coef_val[0][fir_coef_pkg::COEF_MSB:0]); // RULE1 RULE2
      coef_a.outer[5] = $signed(coef_val[1][fir_coef_pkg::COEF_MSB:0]); // RULE3
      coef_a.outer[6] = $signed(coef_val[2][fir_coef_pkg::COEF_MSB:0]); // RULE4
      coef_a.outer[7] = $signed(coef_val[3][fir_coef_pkg::COEF_MSB:0]); // RULE5
      coef_a.center = chan_a_center_tap_coef_i; // RULE8
   end

   // Channel B set only in dual mode
   always_comb begin
      if (single_mode) begin
         for (int k = 0; k < fir_coef_pkg::NUM_OUTER; k++) begin
            coef_b.outer[k] = coef_a.outer[k]; // RULE9
         end
         coef_b.center = coef_a.center;
      end else begin
         coef_b.outer[0] = $signed(
            coef_val[B_TAP1_IDX][fir_coef_pkg::COEF_MSB:0]); // RULE7 RULE1
         for (int k = 1; k < fir_coef_pkg::NUM_OUTER; k++) begin
            coef_b.outer[k] = chan_b_ext_coef_i[(k-1)*fir_coef_pkg::COEF_W +:
               fir_coef_pkg::COEF_W];
         end
         coef_b.center = chan_b_center_tap_coef_i; // RULE8
      end
   end

   fir9_filter u_fir_a (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .valid_i(sample_valid_i),
      .sample_i(sample_a_i),
      .coefs(coef_a.sink),
      .y_o(fir_a_o),
      .y_valid_o(fir_valid_o)
   );

   fir9_filter u_fir_b (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .valid_i(sample_valid_i),
      .sample_i(sample_b_i),
      .coefs(coef_b.sink),
      .y_o(fir_b_o),
      .y_valid_o()
   );

   // Read multiplexer
   always_comb begin
      rdata_d = '0;
      if (rd_i) begin
         for (int i = 0; i < fir_coef_pkg::NUM_COEF_REGS; i++) begin
            if (coef_hit(addr_i, i)) begin
               rdata_d = coef_rb[i]; // RULE6
            end
         end
         if (addr_i == fir_coef_pkg::FILTER_CTRL_OFF) begin
            rdata_d = ctrl_q;
         end
         if (addr_i == fir_coef_pkg::FILTER_STATUS_OFF) begin
            rdata_d = sample_cnt_q;
         end
      end
   end

   // Read data stands one cycle only
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= rdata_d;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   tap6_write_a: assert property ( // RULE2
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP6_OFF
      |=> coef_a.outer[4] == $signed($past(wdata_i[11:0])))
      else $error("tap six coefficient not taken");

   tap7_write_a: assert property ( // RULE3
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP7_OFF
      |=> coef_a.outer[5] == $signed($past(wdata_i[11:0])))
      else $error("tap seven coefficient not taken");

   tap8_write_a: assert property ( // RULE4
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP8_OFF
      |=> coef_a.outer[6] == $signed($past(wdata_i[11:0])))
      else $error("tap eight coefficient not taken");

   tap9_write_a: assert property ( // RULE5
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP9_OFF
      |=> coef_a.outer[7] == $signed($past(wdata_i[11:0])))
      else $error("tap nine coefficient not taken");

   b_tap1_write_a: assert property ( // RULE7
      wr_i && addr_i == fir_coef_pkg::CHAN_B_TAP1_OFF && !single_mode
      |=> coef_b.outer[0] == $signed($past(wdata_i[11:0])))
      else $error("channel B tap one coefficient not taken");

   coef_reset_a: assert property ( // RULE7
      $rose(resetn_i) |-> coef_val[B_TAP1_IDX] == '0 && coef_val[0] == '0)
      else $error("coefficient not zero after reset");

   msb_readback_a: assert property ( // RULE6
      rd_i && any_coef_hit(addr_i)
      |=> rdata_o[fir_coef_pkg::COEF_MSB] == 1'b0
         && (rdata_o[10:0] == $past(coef_val[0][10:0])
            || !$past(coef_hit(addr_i, 0))))
      else $error("coefficient read-back top bit not zero");

   msb_applied_a: assert property ( // RULE6 RULE1
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP6_OFF && wdata_i[11]
      |=> coef_a.outer[4] < 0 ##1 coef_a.outer[4] < 0 || $past(wr_i))
      else $error("written top bit lost from filter coefficient");

   single_share_a: assert property ( // RULE9
      single_mode |-> coef_b.outer[0] == coef_a.outer[0]
         && coef_b.outer[7] == coef_a.outer[7]
         && coef_b.center == coef_a.center)
      else $error("single mode not using channel A set");

   dual_center_a: assert property ( // RULE8 RULE9
      !single_mode |-> coef_b.center == chan_b_center_tap_coef_i
         && coef_a.center == chan_a_center_tap_coef_i)
      else $error("centre tap coefficient not routed");

   filter_latency_a: assert property ( // RULE10
      sample_valid_i |-> ##2 fir_valid_o)
      else $error("filter output not two cycles after sample");

   read_window_a: assert property (
      !$past(rd_i) |-> rdata_o == '0)
      else $error("read data outside its cycle");

   b_tap1_readback_a: assert property ( // RULE7
      rd_i && coef_hit(addr_i, B_TAP1_IDX)
      |=> rdata_o[15:12] == $past(coef_val[B_TAP1_IDX][15:12])
         && rdata_o[10:0] == $past(coef_val[B_TAP1_IDX][10:0]))
      else $error("channel B tap one read-back wrong");

   tap9_readback_a: assert property ( // RULE6
      rd_i && coef_hit(addr_i, 3)
      |=> rdata_o == ($past(coef_val[3]) & 16'hf7ff))
      else $error("tap nine read-back wrong");

   unmapped_read_a: assert property (
      rd_i && !any_coef_hit(addr_i)
         && addr_i != fir_coef_pkg::FILTER_CTRL_OFF
         && addr_i != fir_coef_pkg::FILTER_STATUS_OFF
      |=> rdata_o == '0)
      else $error("unmapped read returned data");

   mode_write_a: assert property ( // RULE9
      wr_i && addr_i == fir_coef_pkg::FILTER_CTRL_OFF
      |=> single_mode == $past(wdata_i[fir_coef_pkg::CTRL_SINGLE_BIT]))
      else $error("filter mode not taken");

   sample_count_a: assert property (
      sample_valid_i |=> sample_cnt_q == $past(sample_cnt_q) + 16'h0001)
      else $error("sample count not advanced");

   valid_origin_a: assert property ( // RULE10
      fir_valid_o |-> $past(sample_valid_i, 2))
      else $error("filter output without a sample");

   single_upper_a: assert property ( // RULE9
      single_mode |-> coef_b.outer[4] == coef_a.outer[4]
         && coef_b.outer[5] == coef_a.outer[5]
         && coef_b.outer[6] == coef_a.outer[6])
      else $error("single mode upper taps not shared");

   write_read_c: cover property (
      wr_i && addr_i == fir_coef_pkg::CHAN_A_TAP9_OFF && wdata_i[11]
      ##1 rd_i && addr_i == fir_coef_pkg::CHAN_A_TAP9_OFF);

   single_run_c: cover property (
      single_mode && sample_valid_i ##2 fir_valid_o);

   dual_b_c: cover property (
      !single_mode && coef_b.outer[0] != 0 && fir_valid_o);

   back_to_back_c: cover property (
      sample_valid_i ##1 sample_valid_i ##1 fir_valid_o);

   mode_switch_c: cover property (
      single_mode ##1 !single_mode);
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic sample_valid_i = 1'b0;
   logic signed [11:0] sample_a_i = 12'h000;
   logic signed [11:0] sample_b_i = 12'h000;
   logic [47:0] a_low = '0;
   logic signed [17:0] a_ctr = '0;
   logic [83:0] b_ext = '0;
   logic signed [17:0] b_ctr = '0;
   logic signed [33:0] fir_a_o;
   logic signed [33:0] fir_b_o;
   logic fir_valid_o;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int n_samp = 0;
   bit single = 1'b0;
   logic [31:0] lfsr = 32'hdfac4228;
   logic [15:0] regv [5];
   logic [11:0] offs [5];
   longint ha [9];
   longint hb [9];
   logic [33:0] qa [$];
   logic [33:0] qb [$];

   fir_tap_coefficient_bank DUT (
      .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sample_valid_i(sample_valid_i), .sample_a_i(sample_a_i),
      .sample_b_i(sample_b_i), .chan_a_low_coef_i(a_low),
      .chan_a_center_tap_coef_i(a_ctr), .chan_b_ext_coef_i(b_ext),
      .chan_b_center_tap_coef_i(b_ctr), .fir_a_o(fir_a_o),
      .fir_b_o(fir_b_o), .fir_valid_o(fir_valid_o));

   always #2 clk_i = ~clk_i;

   function automatic logic [31:0] rand32();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   function automatic longint cf(input logic [11:0] v);
      return longint'($signed(v));
   endfunction

   function automatic longint coef_a(input int k);
      if (k < 4) return cf(a_low[k*12 +: 12]);
      if (k == 4) return longint'(a_ctr);
      return cf(regv[k-5][11:0]);
   endfunction

   function automatic longint coef_b(input int k);
      if (single) return coef_a(k);
      if (k == 0) return cf(regv[4][11:0]);
      if (k < 4) return cf(b_ext[(k-1)*12 +: 12]);
      if (k == 4) return longint'(b_ctr);
      return cf(b_ext[(k-2)*12 +: 12]);
   endfunction

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, e);
   endtask

   task automatic setup();
      logic [95:0] t;
      logic [31:0] r;
      t = {rand32(), rand32(), rand32()};
      @(posedge clk_i);
      a_low <= t[95:48];
      a_ctr <= t[17:0];
      b_ext <= 84'({rand32(), rand32(), rand32()});
      b_ctr <= t[47:30];
      for (int i = 0; i < 5; i++) begin
         r = rand32();
         if (i == 3) r[11] = 1'b1;
         wr(offs[i], r[15:0]);
         regv[i] = r[15:0];
      end
   endtask

   task automatic stream(input int n);
      logic [31:0] r;
      longint sa;
      longint sb;
      for (int i = 0; i < n; i++) begin
         r = rand32();
         if (i < 9) r = 32'h807ff800;
         @(posedge clk_i);
         sample_valid_i <= (r[31] | r[30]);
         sample_a_i <= r[11:0];
         sample_b_i <= r[23:12];
         if (r[31] | r[30]) begin
            for (int k = 8; k > 0; k--) begin
               ha[k] = ha[k-1];
               hb[k] = hb[k-1];
            end
            ha[0] = cf(r[11:0]);
            hb[0] = cf(r[23:12]);
            sa = 0;
            sb = 0;
            for (int k = 0; k < 9; k++) begin
               sa += ha[k] * coef_a(k);
               sb += hb[k] * coef_b(k);
            end
            qa.push_back(sa[33:0]);
            qb.push_back(sb[33:0]);
            n_samp++;
         end
      end
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(34'(qa.size()), 34'h0);
      rd(fir_coef_pkg::FILTER_STATUS_OFF, 16'(n_samp));
   endtask

   always @(negedge clk_i) begin
      if (fir_valid_o === 1'b1) begin
         if (qa.size() == 0) begin
            check(34'h1, 34'h0);
         end else begin
            check(fir_a_o, qa.pop_front());
            check(fir_b_o, qb.pop_front());
         end
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      offs = '{fir_coef_pkg::CHAN_A_TAP6_OFF, fir_coef_pkg::CHAN_A_TAP7_OFF,
               fir_coef_pkg::CHAN_A_TAP8_OFF, fir_coef_pkg::CHAN_A_TAP9_OFF,
               fir_coef_pkg::CHAN_B_TAP1_OFF};
      for (int k = 0; k < 9; k++) begin
         ha[k] = 0;
         hb[k] = 0;
      end
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 5; i++) rd(offs[i], 16'h0000);
      rd(fir_coef_pkg::FILTER_CTRL_OFF, 16'h0000);
      rd(fir_coef_pkg::FILTER_STATUS_OFF, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         regv[i] = (i == 0) ? 16'hffff : 16'(rand32());
         wr(offs[i], regv[i]);
      end
      for (int i = 0; i < 5; i++) rd(offs[i], regv[i] & 16'hf7ff);
      @(posedge clk_i);
      #1 check(rdata_o, 16'h0000);
      wr(12'h424, 16'h1234);
      rd(12'h424, 16'h0000);
      rd(12'h422, 16'h0000);
      @(posedge clk_i);
      addr_i <= fir_coef_pkg::CHAN_A_TAP9_OFF;
      wdata_i <= 16'h0800;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, 16'h0000);
      rd(offs[0], 16'hf7ff);
      $display("test readback done");
      setup();
      stream(200);
      $display("test dual mode done");
      wr(fir_coef_pkg::FILTER_CTRL_OFF, 16'hffff);
      rd(fir_coef_pkg::FILTER_CTRL_OFF, 16'h0001);
      single = 1'b1;
      setup();
      stream(200);
      $display("test single mode done");
      wr(fir_coef_pkg::FILTER_CTRL_OFF, 16'h0000);
      single = 1'b0;
      setup();
      stream(100);
      $display("test dual again done");
      close_out();
   end
endmodule
`default_nettype wire
